// *** frpg_partner.sv ***
`timescale 1ns/1ps
module frpg_partner (
  // Pin drive from the device
  input wire logic gpio1_out,
  input wire logic gpio1_oe_n,
  input wire logic gpio2_out,
  input wire logic gpio2_oe_n,
  input wire logic switch_sync_line_out,
  input wire logic switch_sync_line_oe_n,
  // Peer device pulling the shared line
  input wire logic peer_pull,
  // Resolved pin levels
  output logic gpio1_in,
  output logic gpio2_in,
  output logic switch_sync_line_in
);
  // Every line has a pull-up, so a released line reads high
  assign gpio1_in = gpio1_oe_n ? 1'b1 : gpio1_out;
  assign gpio2_in = gpio2_oe_n ? 1'b1 : gpio2_out;
  assign switch_sync_line_in =
    (switch_sync_line_oe_n ? 1'b1 : switch_sync_line_out) && !peer_pull;
endmodule : frpg_partner

// *** frpg_pkg.sv ***
// Overview of operation
// - A control bit picks auto-retry or permanent latch-off after a latched fault.
// - Retry: fault holds indicator low, timer runs, expiry releases it, dv/dt restart.
// - Fast-recover bit: short circuit turns off, restarts current-limited, no timer.
// - Power cycle or enable below shutdown clears fault, indicator and retry timer.
// - With a fault latched, enable dipping only below lockout is ignored.
// - Second general pin defaults to fault indication, reassignable by pin config.
// - Primary decides faults; secondary pulls sync low and latches off if missed.
// - Secondary latch-off restarts only after supply or enable shutdown cycling.
// - Power good is active high, set only in steady state, low during inrush except a fast-recovery restart.
// - After power-up power good starts low during inrush.
// - Full gate overdrive raises power good after the assert de-glitch delay.
// - Extra-delay bit lengthens the power good assert delay.
// - Power good drops on low output voltage or any fault except a fast-recovered short.
// - Power good output threshold is set by its own register.
// - Power good deassertion waits out its own de-glitch time.
// - First general pin defaults to power good, reassignable by pin config.
// - Primary only: external sync-low fault outside undervoltage or overvoltage latches, drives fault low.
package frpg_pkg;
  localparam int CLK_MHZ = 10;
  localparam int PGA_US = 100;
  localparam int PGA_CYC = PGA_US * CLK_MHZ;
  localparam int PGX_US = 400;
  localparam int PGX_CYC = PGX_US * CLK_MHZ;
  localparam int PGD_US = 20;
  localparam int PGD_CYC = PGD_US * CLK_MHZ;
  localparam int RETRY_US = 1000;
  localparam int RETRY_CYC = RETRY_US * CLK_MHZ;
  localparam int SETTLE_CYC = 4;
  localparam int DW = 32;
  localparam int AW = 8;
  localparam int CW = 13;
  localparam int SW = 3;

  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_PIN = 8'h04;
  localparam logic [AW-1:0] A_THR = 8'h08;
  localparam logic [AW-1:0] A_STAT = 8'h0c;
  localparam logic [AW-1:0] A_IST = 8'h10;
  localparam logic [AW-1:0] A_ICLR = 8'h14;
  localparam logic [AW-1:0] A_IEN = 8'h18;

  localparam logic [3:0] CTRL_RST = 4'h1;
  localparam logic [5:0] PIN_RST = 6'h04;
  localparam logic [7:0] THR_RST = 8'h80;

  localparam logic [1:0] FN_GOOD = 2'h0;
  localparam logic [1:0] FN_FAULT = 2'h1;
  localparam logic [1:0] FN_LEVEL = 2'h2;
  localparam logic [1:0] FN_OFF = 2'h3;

  localparam int EV_W = 5;
  localparam int EV_FAULT = 0;
  localparam int EV_RETRY = 1;
  localparam int EV_SCREC = 2;
  localparam int EV_RISE = 3;
  localparam int EV_FALL = 4;

  typedef enum logic [2:0] {
    ST_OFF, ST_START, ST_ON, ST_RETRY, ST_LATCHED
  } frpg_state_t;

  typedef struct packed {
    logic secondary;
    logic good_assert_extra_delay;
    logic short_circuit_fast_recover;
    logic retry_mode;
  } frpg_cfg_t;

  typedef struct packed {
    logic lvl2;
    logic lvl1;
    logic [1:0] fn2;
    logic [1:0] fn1;
  } frpg_pin_t;

  typedef struct packed {
    logic overtemp;
    logic breaker;
    logic short_circuit;
    logic other_fault;
    logic en_above_uvlo;
    logic en_above_shutdown;
    logic supply_ok;
    logic overvoltage;
    logic gate_full;
    logic vout_good;
  } frpg_sense_t;
endpackage : frpg_pkg

// *** frpg_properties.sv ***
`timescale 1ns/1ps
module frpg_properties #(
  parameter int RETRY_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Inputs
  input wire frpg_pkg::frpg_sense_t sense_raw,
  input wire logic [frpg_pkg::AW-1:0] reg_addr,
  input wire logic [frpg_pkg::DW-1:0] reg_wdata,
  input wire logic reg_we,
  // Outputs
  input wire logic gate_on,
  input wire logic start_current_limited,
  input wire logic [7:0] output_good_threshold,
  input wire logic gpio1_out,
  input wire logic gpio1_oe_n,
  input wire logic gpio2_out,
  input wire logic gpio2_oe_n,
  input wire logic switch_sync_line_out,
  input wire logic switch_sync_line_oe_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Raw counts lead the synchronisers, so the bounds keep two cycles slack
  int on_cnt;
  int lost_cnt;
  logic run_ok;
  assign run_ok = gate_on && sense_raw.gate_full && sense_raw.vout_good;

  always_ff @(posedge clk)
  begin
    if (!rstn || !run_ok)
      on_cnt <= 0;
    else if (on_cnt < 65535)
      on_cnt <= on_cnt + 1;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn || run_ok)
      lost_cnt <= 0;
    else if (lost_cnt < 65535)
      lost_cnt <= lost_cnt + 1;
  end

  property thr_p;
    logic [7:0] v;
    (reg_we && reg_addr == frpg_pkg::A_THR, v = reg_wdata[7:0])
      |-> ##2 output_good_threshold == v;
  endproperty

  thr_copy_a: assert property (thr_p)
    else $error("threshold output wrong");
  good_rise_a: assert property (
    $rose(gpio1_oe_n) |-> on_cnt >= frpg_pkg::PGA_CYC - 2)
    else $error("power good rose early");
  good_fall_a: assert property (
    $fell(gpio1_oe_n) |-> lost_cnt >= frpg_pkg::PGD_CYC - 2)
    else $error("power good fell early");
  good_lost_a: assert property (
    lost_cnt > frpg_pkg::PGD_CYC + 4 |-> !gpio1_oe_n)
    else $error("power good held without steady state");
  fault_pin_a: assert property (
    $rose(sense_raw.other_fault) && gate_on |-> ##[2:6] !gpio2_oe_n)
    else $error("fault pin not pulled");
  shutdown_clear_a: assert property (
    !sense_raw.en_above_shutdown [*6] |-> gpio2_oe_n && !gate_on)
    else $error("shutdown did not clear");
  sync_off_a: assert property (
    !gate_on [*3] |-> !switch_sync_line_oe_n)
    else $error("sync line released while off");
  od_low_a: assert property (
    !(gpio1_out || gpio2_out || switch_sync_line_out))
    else $error("open drain output driven high");
  limited_quiet_a: assert property (
    start_current_limited |-> gpio2_oe_n)
    else $error("fault pin low on fast recovery");

  cover property ($rose(gpio1_oe_n));
  cover property ($fell(gpio2_oe_n));
  cover property ($rose(start_current_limited));
endmodule : frpg_properties

bind frpg_top frpg_properties #(.RETRY_CYCLES(RETRY_CYCLES)) props_u (
  .clk, .rstn, .sense_raw, .reg_addr, .reg_wdata, .reg_we, .gate_on,
  .start_current_limited, .output_good_threshold, .gpio1_out, .gpio1_oe_n,
  .gpio2_out, .gpio2_oe_n, .switch_sync_line_out, .switch_sync_line_oe_n
);

// *** frpg_top.sv ***
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps

module frpg_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : frpg_sync

module frpg_top #(
  parameter int RETRY_CYCLES = frpg_pkg::RETRY_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Comparator and lockout sense
  input wire frpg_pkg::frpg_sense_t sense_raw,
  // Register port
  input wire logic [frpg_pkg::AW-1:0] reg_addr,
  input wire logic [frpg_pkg::DW-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [frpg_pkg::DW-1:0] reg_rdata,
  // Gate driver
  output logic gate_on,
  output logic start_current_limited,
  output logic [7:0] output_good_threshold,
  // Open-drain pins
  input wire logic gpio1_in,
  output logic gpio1_out,
  output logic gpio1_oe_n,
  input wire logic gpio2_in,
  output logic gpio2_out,
  output logic gpio2_oe_n,
  input wire logic switch_sync_line_in,
  output logic switch_sync_line_out,
  output logic switch_sync_line_oe_n,
  // Interrupt
  output logic irq
);
  localparam int RW = $clog2(RETRY_CYCLES + 1);
  localparam int IW = $bits(frpg_pkg::frpg_sense_t) + 3;

  frpg_pkg::frpg_sense_t sense;
  logic gpio1_s;
  logic gpio2_s;
  logic sync_s;
  frpg_pkg::frpg_state_t state_reg;
  frpg_pkg::frpg_cfg_t cfg_reg;
  frpg_pkg::frpg_pin_t pin_reg;
  logic [7:0] thr_reg;
  logic fault_reg;
  logic limited_reg;
  logic screc_reg;
  logic failsafe_reg;
  logic [RW-1:0] retry_cnt_reg;
  logic [1:0] settle_reg;
  logic [frpg_pkg::CW-1:0] pga_cnt_reg;
  logic [frpg_pkg::CW-1:0] pgd_cnt_reg;
  logic [frpg_pkg::CW-1:0] pga_target;
  logic good_reg;
  logic [frpg_pkg::EV_W-1:0] ist_reg;
  logic [frpg_pkg::EV_W-1:0] ist_next;
  logic [frpg_pkg::EV_W-1:0] ien_reg;
  logic [frpg_pkg::EV_W-1:0] events;

  frpg_sync #(
    .W(IW)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({sense_raw, gpio1_in, gpio2_in, switch_sync_line_in}),
    .q({sense, gpio1_s, gpio2_s, sync_s})
  );

  logic running;
  logic clear_all;
  logic uv_or_ov;
  logic settled;
  logic sync_low;
  logic ext_fault;
  logic sc_fast;
  logic local_fault;
  logic failsafe;
  logic latch_event;
  logic retry_done;
  logic good_cond;

  always_comb
  begin
    running = (state_reg == frpg_pkg::ST_START)
      || (state_reg == frpg_pkg::ST_ON);
    // Losing supply counts as a power cycle
    clear_all = !sense.en_above_shutdown || !sense.supply_ok;
    uv_or_ov = !sense.supply_ok || sense.overvoltage;
    // Our own pull-down needs time to clear through the synchroniser
    settled = (settle_reg == 2'(frpg_pkg::SETTLE_CYC - 1));
    sync_low = running && settled && !sync_s;
    ext_fault = sync_low && !cfg_reg.secondary && !uv_or_ov;
    sc_fast = running && sense.short_circuit
      && cfg_reg.short_circuit_fast_recover;
    local_fault = sense.overtemp || sense.breaker || sense.other_fault
      || (sense.short_circuit && !cfg_reg.short_circuit_fast_recover);
    // Sync still high means the primary has not reacted
    failsafe = running && cfg_reg.secondary && local_fault && sync_s;
    latch_event = running && (local_fault || ext_fault);
    retry_done = (state_reg == frpg_pkg::ST_RETRY)
      && (retry_cnt_reg == RW'(RETRY_CYCLES - 1));
  end

  always_ff @(posedge clk)
  begin
    if (!rstn || !running)
      settle_reg <= '0;
    else if (!settled)
      settle_reg <= settle_reg + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_reg <= frpg_pkg::ST_OFF;
      fault_reg <= 1'b0;
      limited_reg <= 1'b0;
      screc_reg <= 1'b0;
      failsafe_reg <= 1'b0;
    end
    else if (clear_all)
    begin
      state_reg <= frpg_pkg::ST_OFF;
      fault_reg <= 1'b0;
      limited_reg <= 1'b0;
      screc_reg <= 1'b0;
      failsafe_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        frpg_pkg::ST_OFF:
        begin
          if (sense.en_above_uvlo && !sense.overvoltage)
          begin
            state_reg <= frpg_pkg::ST_START;
            limited_reg <= screc_reg;
          end
        end
        frpg_pkg::ST_START, frpg_pkg::ST_ON:
        begin
          if (latch_event)
          begin
            fault_reg <= 1'b1;
            screc_reg <= 1'b0;
            limited_reg <= 1'b0;
            failsafe_reg <= failsafe;
            if (cfg_reg.retry_mode && !failsafe)
              state_reg <= frpg_pkg::ST_RETRY;
            else
              state_reg <= frpg_pkg::ST_LATCHED;
          end
          else if (sc_fast)
          begin
            // Drop the gate for a cycle; the OFF state restarts it limited
            state_reg <= frpg_pkg::ST_OFF;
            limited_reg <= 1'b1;
            screc_reg <= 1'b1;
          end
          else if (!sense.en_above_uvlo || sense.overvoltage || sync_low)
          begin
            state_reg <= frpg_pkg::ST_OFF;
            screc_reg <= 1'b0;
          end
          else if (state_reg == frpg_pkg::ST_START && sense.gate_full)
          begin
            state_reg <= frpg_pkg::ST_ON;
            screc_reg <= 1'b0;
            limited_reg <= 1'b0;
          end
        end
        frpg_pkg::ST_RETRY:
        begin
          // Lockout dips are ignored while a fault is held
          if (retry_done)
          begin
            state_reg <= frpg_pkg::ST_OFF;
            fault_reg <= 1'b0;
          end
        end
        frpg_pkg::ST_LATCHED:
        begin
          state_reg <= frpg_pkg::ST_LATCHED;
        end
        default:
        begin
          state_reg <= frpg_pkg::ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn || clear_all || state_reg != frpg_pkg::ST_RETRY)
      retry_cnt_reg <= '0;
    else if (!retry_done)
      retry_cnt_reg <= retry_cnt_reg + RW'(1);
  end

  always_comb
  begin
    // A fast-recovery restart keeps power good while the output holds
    good_cond = sense.vout_good && ((state_reg == frpg_pkg::ST_ON
      && sense.gate_full) || (good_reg && screc_reg));
    if (cfg_reg.good_assert_extra_delay)
      pga_target = frpg_pkg::CW'(frpg_pkg::PGX_CYC - 1);
    else
      pga_target = frpg_pkg::CW'(frpg_pkg::PGA_CYC - 1);
  end

  always_ff @(posedge clk)
  begin
    if (!rstn || !good_cond || good_reg)
      pga_cnt_reg <= '0;
    else
      pga_cnt_reg <= pga_cnt_reg + frpg_pkg::CW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (!rstn || good_cond || !good_reg)
      pgd_cnt_reg <= '0;
    else
      pgd_cnt_reg <= pgd_cnt_reg + frpg_pkg::CW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      good_reg <= 1'b0;
    else if (good_cond && !good_reg && pga_cnt_reg == pga_target)
      good_reg <= 1'b1;
    else if (!good_cond && good_reg
      && pgd_cnt_reg == frpg_pkg::CW'(frpg_pkg::PGD_CYC - 1))
      good_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cfg_reg <= frpg_pkg::CTRL_RST;
      pin_reg <= frpg_pkg::PIN_RST;
      thr_reg <= frpg_pkg::THR_RST;
      ien_reg <= '0;
    end
    else if (reg_we)
    begin
      if (reg_addr == frpg_pkg::A_CTRL)
        cfg_reg <= reg_wdata[$bits(frpg_pkg::frpg_cfg_t)-1:0];
      if (reg_addr == frpg_pkg::A_PIN)
        pin_reg <= reg_wdata[$bits(frpg_pkg::frpg_pin_t)-1:0];
      if (reg_addr == frpg_pkg::A_THR)
        thr_reg <= reg_wdata[7:0];
      if (reg_addr == frpg_pkg::A_IEN)
        ien_reg <= reg_wdata[frpg_pkg::EV_W-1:0];
    end
  end

  always_comb
  begin
    events = '0;
    events[frpg_pkg::EV_FAULT] = running && !clear_all && latch_event;
    events[frpg_pkg::EV_RETRY] = !clear_all && retry_done;
    events[frpg_pkg::EV_SCREC] = !clear_all && !latch_event && sc_fast;
    events[frpg_pkg::EV_RISE] = good_cond && !good_reg
      && pga_cnt_reg == pga_target;
    events[frpg_pkg::EV_FALL] = !good_cond && good_reg
      && pgd_cnt_reg == frpg_pkg::CW'(frpg_pkg::PGD_CYC - 1);
    ist_next = ist_reg;
    if (reg_we && reg_addr == frpg_pkg::A_ICLR)
      ist_next = ist_next & ~reg_wdata[frpg_pkg::EV_W-1:0];
    // New events win over a clear in the same cycle
    ist_next = ist_next | events;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ist_reg <= '0;
      irq <= 1'b0;
    end
    else
    begin
      ist_reg <= ist_next;
      irq <= |(ist_next & ien_reg);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn || !reg_re)
      reg_rdata <= '0;
    else
    begin
      unique case (reg_addr)
        frpg_pkg::A_CTRL: reg_rdata <= frpg_pkg::DW'(cfg_reg);
        frpg_pkg::A_PIN: reg_rdata <= frpg_pkg::DW'(pin_reg);
        frpg_pkg::A_THR: reg_rdata <= frpg_pkg::DW'(thr_reg);
        frpg_pkg::A_STAT:
          reg_rdata <= frpg_pkg::DW'({sync_s, gpio2_s, gpio1_s,
            failsafe_reg, screc_reg, limited_reg, good_reg, fault_reg,
            frpg_pkg::SW'(state_reg)});
        frpg_pkg::A_IST: reg_rdata <= frpg_pkg::DW'(ist_reg);
        frpg_pkg::A_IEN: reg_rdata <= frpg_pkg::DW'(ien_reg);
        default: reg_rdata <= '0;
      endcase
    end
  end

  function automatic logic pull_low(
    input logic [1:0] fn,
    input logic lvl,
    input logic good,
    input logic fault
  );
    logic pull;
    pull = 1'b0;
    unique case (fn)
      frpg_pkg::FN_GOOD: pull = !good;
      frpg_pkg::FN_FAULT: pull = fault;
      frpg_pkg::FN_LEVEL: pull = !lvl;
      frpg_pkg::FN_OFF: pull = 1'b0;
    endcase
    return pull;
  endfunction : pull_low

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      gpio1_oe_n <= 1'b0;
      gpio2_oe_n <= 1'b1;
      gpio1_out <= 1'b0;
      gpio2_out <= 1'b0;
    end
    else
    begin
      gpio1_oe_n <= !pull_low(pin_reg.fn1, pin_reg.lvl1, good_reg,
        fault_reg);
      gpio2_oe_n <= !pull_low(pin_reg.fn2, pin_reg.lvl2, good_reg,
        fault_reg);
      gpio1_out <= 1'b0;
      gpio2_out <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      gate_on <= 1'b0;
      start_current_limited <= 1'b0;
      output_good_threshold <= frpg_pkg::THR_RST;
      switch_sync_line_oe_n <= 1'b0;
      switch_sync_line_out <= 1'b0;
    end
    else
    begin
      gate_on <= running;
      start_current_limited <= limited_reg;
      output_good_threshold <= thr_reg;
      // Holding sync low keeps the whole chain off
      switch_sync_line_oe_n <= running;
      switch_sync_line_out <= 1'b0;
    end
  end
endmodule : frpg_top

// *** tb_frpg.sv ***
`timescale 1ns/1ps
module tb;
  localparam int RT = 20;
  logic clk, rstn, reg_we, reg_re, gate_on, start_current_limited, irq;
  frpg_pkg::frpg_sense_t sense_raw;
  logic [7:0] reg_addr, output_good_threshold;
  logic [31:0] reg_wdata, reg_rdata, seed;
  logic gpio1_in, gpio1_out, gpio1_oe_n, gpio2_in, gpio2_out, gpio2_oe_n;
  logic switch_sync_line_in, switch_sync_line_out, switch_sync_line_oe_n;
  logic peer_pull;
  int miscompares, samples_checked, n, ist_m;

  frpg_top #(.RETRY_CYCLES(RT)) dut_u (
    .clk, .rstn, .sense_raw, .reg_addr, .reg_wdata, .reg_we, .reg_re,
    .reg_rdata, .gate_on, .start_current_limited, .output_good_threshold,
    .gpio1_in, .gpio1_out, .gpio1_oe_n, .gpio2_in, .gpio2_out, .gpio2_oe_n,
    .switch_sync_line_in, .switch_sync_line_out, .switch_sync_line_oe_n,
    .irq
  );
  frpg_partner peer_u (
    .gpio1_out, .gpio1_oe_n, .gpio2_out, .gpio2_oe_n, .switch_sync_line_out,
    .switch_sync_line_oe_n, .peer_pull, .gpio1_in, .gpio2_in,
    .switch_sync_line_in
  );

  always #50 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Last waited count must lie in lo..hi
  task automatic span(input int lo, input int hi);
    chk((n >= lo && n <= hi) ? 32'(lo) : 32'(n), 32'(lo));
  endtask : span

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
    if (a == frpg_pkg::A_ICLR)
      ist_m = ist_m & ~int'(d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  // Bounded wait: 1 good pin, 2 fault pin, 3 gate, 4 limited start
  task automatic await(input int sel, input logic v, input int lim);
    logic p;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
      p = sel == 1 ? gpio1_oe_n : sel == 2 ? gpio2_oe_n :
          sel == 3 ? gate_on : start_current_limited;
    end
    while (p !== v && n < lim);
  endtask : await

  task automatic supply(input logic on);
    @(posedge clk);
    sense_raw.en_above_uvlo <= on;
    sense_raw.en_above_shutdown <= on;
  endtask : supply

  initial
  begin
    repeat (30000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    sense_raw = '0;
    sense_raw.supply_ok = 1'b1;
    sense_raw.gate_full = 1'b1;
    sense_raw.vout_good = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    peer_pull = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    ist_m = 0;
    seed = 32'h4662b6fa;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk(gpio1_oe_n, 1'b0);
    chk(gpio2_oe_n, 1'b1);
    rd(frpg_pkg::A_CTRL, 32'(frpg_pkg::CTRL_RST));
    rd(frpg_pkg::A_PIN, 32'(frpg_pkg::PIN_RST));
    rd(8'h1c, 32'h0);
    seed = lfsr(seed);
    wr(frpg_pkg::A_THR, seed);
    rd(frpg_pkg::A_THR, {24'h0, seed[7:0]});
    chk(output_good_threshold, seed[7:0]);
    $display("registers done");
    for (int k = 0; k < 2; k++)
    begin
      int lo;
      lo = k ? frpg_pkg::PGX_CYC : frpg_pkg::PGA_CYC;
      wr(frpg_pkg::A_CTRL, k ? 32'h5 : 32'h1);
      supply(1'b1);
      await(1, 1'b1, lo + 20);
      span(lo, lo + 8);
      supply(1'b0);
      await(1, 1'b0, 300);
      span(frpg_pkg::PGD_CYC, frpg_pkg::PGD_CYC + 8);
      ist_m = ist_m | (1 << frpg_pkg::EV_RISE) | (1 << frpg_pkg::EV_FALL);
    end
    $display("power good done");
    chk(irq, 1'b0);
    wr(frpg_pkg::A_IEN, 32'h1f);
    repeat (2) @(posedge clk);
    #1;
    chk(irq, 1'b1);
    rd(frpg_pkg::A_IST, ist_m);
    wr(frpg_pkg::A_ICLR, 32'h1f);
    repeat (2) @(posedge clk);
    #1;
    chk(irq, 1'b0);
    $display("interrupt done");
    wr(frpg_pkg::A_CTRL, 32'h1);
    supply(1'b1);
    await(3, 1'b1, 20);
    repeat (10) @(posedge clk);
    sense_raw.other_fault <= 1'b1;
    await(2, 1'b0, 10);
    span(2, 6);
    @(posedge clk);
    sense_raw.other_fault <= 1'b0;
    await(2, 1'b1, RT + 10);
    span(RT - 3, RT + 2);
    await(3, 1'b1, 10);
    span(1, 8);
    chk(start_current_limited, 1'b0);
    ist_m = (1 << frpg_pkg::EV_FAULT) | (1 << frpg_pkg::EV_RETRY);
    rd(frpg_pkg::A_IST, ist_m);
    wr(frpg_pkg::A_ICLR, 32'h1f);
    $display("retry done");
    for (int m = 0; m < 2; m++)
    begin
      wr(frpg_pkg::A_CTRL, 32'h0);
      supply(1'b1);
      await(3, 1'b1, 20);
      @(posedge clk);
      sense_raw.other_fault <= 1'b1;
      await(2, 1'b0, 10);
      @(posedge clk);
      sense_raw.other_fault <= 1'b0;
      repeat (2 * RT) @(posedge clk);
      #1;
      chk(gpio2_oe_n, 1'b0);
      chk(switch_sync_line_oe_n, 1'b0);
      @(posedge clk);
      sense_raw.en_above_uvlo <= 1'b0;
      repeat (10) @(posedge clk);
      #1;
      chk(gpio2_oe_n, 1'b0);
      @(posedge clk);
      if (m == 0)
        sense_raw.en_above_shutdown <= 1'b0;
      else
        rstn <= 1'b0;
      await(2, 1'b1, 10);
      span(1, 6);
      @(posedge clk);
      rstn <= 1'b1;
    end
    $display("latch-off done");
    wr(frpg_pkg::A_CTRL, 32'h0);
    supply(1'b1);
    await(3, 1'b1, 20);
    repeat (8) @(posedge clk);
    peer_pull <= 1'b1;
    await(2, 1'b0, 10);
    span(2, 6);
    @(posedge clk);
    peer_pull <= 1'b0;
    repeat (2 * RT) @(posedge clk);
    #1;
    chk(gpio2_oe_n, 1'b0);
    chk(gate_on, 1'b0);
    supply(1'b0);
    await(2, 1'b1, 10);
    span(1, 6);
    $display("sync fault done");
    wr(frpg_pkg::A_CTRL, 32'h9);
    supply(1'b1);
    await(3, 1'b1, 20);
    repeat (8) @(posedge clk);
    sense_raw.other_fault <= 1'b1;
    await(3, 1'b0, 10);
    span(2, 6);
    @(posedge clk);
    sense_raw.other_fault <= 1'b0;
    repeat (2 * RT) @(posedge clk);
    #1;
    chk(switch_sync_line_oe_n, 1'b0);
    chk(gpio2_oe_n, 1'b0);
    chk(gate_on, 1'b0);
    rd(frpg_pkg::A_STAT, 32'h8c);
    supply(1'b0);
    await(2, 1'b1, 10);
    span(1, 6);
    $display("failsafe done");
    wr(frpg_pkg::A_CTRL, 32'h3);
    supply(1'b1);
    await(3, 1'b1, 20);
    repeat (8) @(posedge clk);
    sense_raw.short_circuit <= 1'b1;
    repeat (2) @(posedge clk);
    sense_raw.short_circuit <= 1'b0;
    await(4, 1'b1, 12);
    span(1, 10);
    chk(gate_on, 1'b0);
    await(3, 1'b1, 4);
    span(1, 2);
    chk(gpio2_oe_n, 1'b1);
    $display("fast recovery done");
    conclude();
  end
endmodule : tb
